// File: src/ffm_params.svh
`ifndef FFM_PARAMS_SVH
`define FFM_PARAMS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define FFM_IDX_CFG 8'h15
`define FFM_IDX_SRC 8'h16
`define FFM_IDX_THS 8'h17
`define FFM_IDX_THS_X_MSB 8'h73
`define FFM_IDX_DBNC 8'h7A
`define FFM_IDX_IRQ_STAT 8'h7B
`define FFM_IDX_IRQ_MASK 8'h7C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FFM_CFG_LATCH 7
`define FFM_CFG_MOTION 6
`define FFM_CFG_ZEN 5
`define FFM_CFG_YEN 4
`define FFM_CFG_XEN 3
`define FFM_SRC_ACTIVE 7
`define FFM_THS_DBCNTM 7
`define FFM_MSB_AXIS_SEL 7
`define FFM_COMMON_SHIFT 6

// ----------------------------------------------------------------
// Reset values and debounce default
// ----------------------------------------------------------------
`define FFM_RST_CFG 8'h00
`define FFM_RST_THS 8'h00
`define FFM_RST_AXIS_THS 13'h0000
`define FFM_RST_DBNC 8'h00
`define FFM_RST_MASK 8'h00

`endif

// File: src/ffm_pkg.sv
package ffm_pkg;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    // Combination of the per-axis flags
    typedef enum logic {
        FFM_FREEFALL = 1'b0,
        FFM_MOTION = 1'b1
    } ffm_comb_e;

    typedef logic [13:0] ffm_sample_t;
    typedef logic [12:0] ffm_axis_ths_t;

endpackage

// File: src/ffm_axis_cmp.sv
`timescale 1ns/1ps
`include "ffm_params.svh"

module ffm_axis_cmp import ffm_pkg::*; #(
    parameter int DW = 14,
    parameter int TW = 13,
    parameter int CW = 7
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Sample in
    input wire logic sample_valid,
    input wire logic [DW-1:0] sample,
    // Threshold selection
    input wire logic [TW-1:0] axis_ths,
    input wire logic [CW-1:0] common_ths,
    input wire logic use_axis_ths,
    // Registered result
    output logic above_q,
    output logic neg_q,
    output logic valid_q
);

    localparam int SH = `FFM_COMMON_SHIFT;
    localparam int PADW = DW - CW - SH;

    logic [DW-1:0] mag;
    logic [DW-1:0] thr;

    // Unsigned magnitude; full-scale negative maps to 2^(DW-1) cleanly
    always_comb begin
        mag = sample[DW-1] ? DW'(-sample) : sample;
    end

    // Common 7-bit value scaled to sample counts, 63 mg per step [RULE_14]
    always_comb begin
        if (use_axis_ths) begin // [RULE_05]
            thr = {{(DW-TW){1'b0}}, axis_ths}; // [RULE_04]
        end else begin
            thr = {{PADW{1'b0}}, common_ths, {SH{1'b0}}}; // [RULE_04]
        end
    end

    // Compare once per new sample
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            above_q <= 1'b0;
            neg_q <= 1'b0;
        end else if (sample_valid) begin // [RULE_17]
            above_q <= (mag > thr);
            neg_q <= sample[DW-1];
        end
    end

    // Result strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            valid_q <= 1'b0;
        end else begin
            valid_q <= sample_valid;
        end
    end

    AST_COMMON_BELOW: assert property (@(posedge pclk) disable iff (!presetn)
        (sample_valid && !use_axis_ths && mag <= {{PADW{1'b0}}, common_ths, {SH{1'b0}}}) |=> !above_q) // [RULE_04]
        else $error("common threshold compare wrong");
    AST_AXIS_ABOVE: assert property (@(posedge pclk) disable iff (!presetn)
        (sample_valid && use_axis_ths && mag > {{(DW-TW){1'b0}}, axis_ths}) |=> above_q) // [RULE_05]
        else $error("per-axis threshold compare wrong");

endmodule // ffm_axis_cmp

// File: src/ffm_detector.sv
// Behaviour
// RULE_01 - With motion mode off, the event fires only when every enabled axis is below threshold.
// RULE_02 - With motion mode on, the event fires when any enabled axis is above threshold.
// RULE_03 - The common threshold sits at index 0x17 and the per-axis thresholds at indices 0x73 to 0x78.
// RULE_04 - Thresholds are unsigned: one shared 7-bit value or a 13-bit value per axis.
// RULE_05 - The per-axis select bit picks the 13-bit axis thresholds, otherwise the shared one is used.
// RULE_06 - In latched mode a detected event stays in the flag until the source register is read.
// RULE_07 - In live mode the flag follows the current detection result at every evaluation.
// RULE_08 - In latched mode all source flags freeze when the event flag sets.
// RULE_09 - While an event is held, new axis flags do not change the source register until it is read.
// RULE_10 - Each of X, Y and Z has its own enable bit for the detection function.
// RULE_11 - A cleared axis enable removes that axis; a set one raises its flag on a threshold crossing.
// RULE_12 - The logic that sets the event flag is debounced in a way chosen by a mode bit.
// RULE_13 - Debounce mode 1 clears the counter when the condition drops; mode 0 counts it down to zero.
// RULE_14 - The common 7-bit threshold has a fixed step of 63 mg.
// RULE_15 - The event flag is raised by the configured combination and, with the enable, drives the interrupt.
// RULE_16 - The source register holds the event flag in bit 7 and Z, Y, X event and polarity in bits 5 to 0.
// RULE_17 - Comparison, combination and debounce are evaluated once per new acceleration sample.
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`include "ffm_params.svh"

module ffm_detector import ffm_pkg::*; #(
    parameter int PADDR_W = 12,
    parameter int DW = 14,
    parameter int CNT_W = 8
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Acceleration samples
    input wire logic sample_valid,
    input wire logic [DW-1:0] sample_x,
    input wire logic [DW-1:0] sample_y,
    input wire logic [DW-1:0] sample_z,
    // Event outputs
    output logic event_active_flag,
    output logic irq
);
    default clocking cb_pclk @(posedge pclk); endclocking // Every assertion here runs on pclk
    default disable iff (!presetn);

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [7:3] cfg_q;
    logic [7:0] ths_q;
    ffm_axis_ths_t axis_ths_q [3];
    logic axis_sel_q;
    logic [CNT_W-1:0] dbnc_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic ea_q;
    logic [5:0] flags_q;
    logic [0:0] stat_q;
    logic [0:0] mask_q;
    logic [31:0] rdata_q;
    logic err_q;

    // Decoded index match, used by write, read and side-effect logic
    function automatic logic idx_hit(input logic [PADDR_W-1:0] a, input logic [7:0] idx);
        idx_hit = (a[PADDR_W-1:2] == (PADDR_W-2)'(idx)) && (a[1:0] == 2'b00);
    endfunction

    logic setup;
    logic wr_acc;
    logic rd_acc;
    logic src_read;
    assign setup = psel && !penable;
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;
    assign src_read = rd_acc && idx_hit(paddr, `FFM_IDX_SRC);

    ffm_comb_e comb;
    logic latch_en;
    logic [2:0] axis_en;
    assign comb = ffm_comb_e'(cfg_q[`FFM_CFG_MOTION]);
    assign latch_en = cfg_q[`FFM_CFG_LATCH];
    assign axis_en = {cfg_q[`FFM_CFG_ZEN], cfg_q[`FFM_CFG_YEN], cfg_q[`FFM_CFG_XEN]}; // [RULE_10]

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    // Configuration and common threshold
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= 5'(`FFM_RST_CFG >> 3);
            ths_q <= `FFM_RST_THS;
            dbnc_q <= `FFM_RST_DBNC;
            mask_q <= 1'(`FFM_RST_MASK);
            axis_sel_q <= 1'b0;
        end else if (wr_acc) begin
            if (idx_hit(paddr, `FFM_IDX_CFG)) begin
                cfg_q <= pwdata[7:3];
            end
            if (idx_hit(paddr, `FFM_IDX_THS)) begin // [RULE_03]
                ths_q <= pwdata[7:0];
            end
            if (idx_hit(paddr, `FFM_IDX_DBNC)) begin
                dbnc_q <= pwdata[CNT_W-1:0];
            end
            if (idx_hit(paddr, `FFM_IDX_IRQ_MASK)) begin
                mask_q <= pwdata[0:0];
            end
            if (idx_hit(paddr, `FFM_IDX_THS_X_MSB)) begin
                axis_sel_q <= pwdata[`FFM_MSB_AXIS_SEL];
            end
        end
    end

    // Per-axis thresholds: MSB index 0x73+2n, LSB index 0x74+2n
    for (genvar n = 0; n < 3; n++) begin : g_axis_ths
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                axis_ths_q[n] <= `FFM_RST_AXIS_THS;
            end else if (wr_acc) begin
                if (idx_hit(paddr, 8'(`FFM_IDX_THS_X_MSB + 2 * n))) begin // [RULE_03]
                    axis_ths_q[n][12:6] <= pwdata[6:0];
                end
                if (idx_hit(paddr, 8'(`FFM_IDX_THS_X_MSB + 2 * n + 1))) begin
                    axis_ths_q[n][5:0] <= pwdata[5:0];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Per-axis comparison
    // ----------------------------------------------------------------
    logic [DW-1:0] samples [3];
    logic [2:0] above;
    logic [2:0] neg;
    logic [2:0] vld;
    assign samples[0] = sample_x;
    assign samples[1] = sample_y;
    assign samples[2] = sample_z;

    for (genvar n = 0; n < 3; n++) begin : g_cmp
        ffm_axis_cmp #(
            .DW(DW),
            .TW(13),
            .CW(7)
        ) u_cmp (
            .pclk(pclk),
            .presetn(presetn),
            .sample_valid(sample_valid),
            .sample(samples[n]),
            .axis_ths(axis_ths_q[n]),
            .common_ths(ths_q[6:0]),
            .use_axis_ths(axis_sel_q),
            .above_q(above[n]),
            .neg_q(neg[n]),
            .valid_q(vld[n])
        );
    end

    // ----------------------------------------------------------------
    // Combination and debounce
    // ----------------------------------------------------------------
    logic eval;
    logic [2:0] axis_hit;
    logic cond;
    logic det;
    assign eval = vld[0]; // [RULE_17]

    // Per-axis event: disabled axes never raise a flag
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            axis_hit[i] = axis_en[i] && ((comb == FFM_MOTION) ? above[i] : !above[i]); // [RULE_11]
        end
    end

    // AND of enabled low-g axes, or OR of enabled high-g axes
    always_comb begin
        if (comb == FFM_MOTION) begin
            cond = |axis_hit; // [RULE_02]
        end else begin
            cond = (axis_en != 3'b000) && (axis_hit == axis_en); // [RULE_01]
        end
    end

    // Counter climbs to the debounce count; event fires on reaching it
    always_comb begin
        cnt_d = cnt_q;
        if (cond) begin
            if (cnt_q < dbnc_q) begin
                cnt_d = cnt_q + 1'b1;
            end
        end else if (ths_q[`FFM_THS_DBCNTM]) begin
            cnt_d = '0; // [RULE_13]
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - 1'b1; // [RULE_13]
        end
        det = cond && (cnt_d >= dbnc_q); // [RULE_12]
    end

    // Counter advances only on evaluation strobes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
        end else if (eval) begin
            cnt_q <= cnt_d; // [RULE_17]
        end
    end

    // ----------------------------------------------------------------
    // Source register
    // ----------------------------------------------------------------
    logic hold;
    logic ev_set;
    logic [5:0] flags_new;
    assign hold = latch_en && ea_q;
    assign ev_set = eval && det && !ea_q;
    assign flags_new = {axis_hit[2], neg[2], axis_hit[1], neg[1], axis_hit[0], neg[0]}; // [RULE_16]

    // Event flag; a detection in the read cycle wins over the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ea_q <= 1'b0;
        end else if (eval && det) begin
            ea_q <= 1'b1; // [RULE_15]
        end else if (eval && !latch_en) begin
            ea_q <= 1'b0; // [RULE_07]
        end else if (src_read && latch_en) begin
            ea_q <= 1'b0; // [RULE_06]
        end
    end

    // Axis flags freeze while an event is held
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= '0;
        end else if (eval && !hold) begin
            flags_q <= flags_new; // [RULE_08]
        end else if (src_read && latch_en && !(eval && det)) begin
            flags_q <= '0; // [RULE_09]
        end
    end

    assign event_active_flag = ea_q;

    // ----------------------------------------------------------------
    // Interrupt
    // ----------------------------------------------------------------
    // Sticky status, write one to clear; a new event beats the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= '0;
        end else if (ev_set) begin
            stat_q <= 1'b1;
        end else if (wr_acc && idx_hit(paddr, `FFM_IDX_IRQ_STAT) && pwdata[0]) begin
            stat_q <= 1'b0;
        end
    end

    assign irq = |(stat_q & mask_q); // [RULE_15]

    // ----------------------------------------------------------------
    // APB read path
    // ----------------------------------------------------------------
    // Read data sampled in the setup cycle so it comes from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= '0;
            err_q <= 1'b0;
        end else if (setup) begin
            rdata_q <= '0;
            err_q <= 1'b0;
            if (idx_hit(paddr, `FFM_IDX_CFG)) begin
                rdata_q[7:3] <= cfg_q;
            end else if (idx_hit(paddr, `FFM_IDX_SRC)) begin
                rdata_q[7:0] <= {ea_q, 1'b0, flags_q}; // [RULE_16]
            end else if (idx_hit(paddr, `FFM_IDX_THS)) begin
                rdata_q[7:0] <= ths_q;
            end else if (idx_hit(paddr, `FFM_IDX_DBNC)) begin
                rdata_q[CNT_W-1:0] <= dbnc_q;
            end else if (idx_hit(paddr, `FFM_IDX_IRQ_STAT)) begin
                rdata_q[0:0] <= stat_q;
            end else if (idx_hit(paddr, `FFM_IDX_IRQ_MASK)) begin
                rdata_q[0:0] <= mask_q;
            end else if (paddr[PADDR_W-1:2] >= (PADDR_W-2)'(`FFM_IDX_THS_X_MSB)
                    && paddr[PADDR_W-1:2] < (PADDR_W-2)'(`FFM_IDX_THS_X_MSB + 6) && paddr[1:0] == 2'b00) begin
                for (int i = 0; i < 3; i++) begin
                    if (idx_hit(paddr, 8'(`FFM_IDX_THS_X_MSB + 2 * i))) begin
                        rdata_q[7:0] <= {(i == 0) ? axis_sel_q : 1'b0, axis_ths_q[i][12:6]};
                    end
                    if (idx_hit(paddr, 8'(`FFM_IDX_THS_X_MSB + 2 * i + 1))) begin
                        rdata_q[7:0] <= {2'b00, axis_ths_q[i][5:0]};
                    end
                end
            end else begin
                err_q <= 1'b1; // Unmapped address
            end
        end
    end

    // Zero wait states: every access phase completes at once
    assign pready = 1'b1;
    assign prdata = rdata_q;
    assign pslverr = psel && penable && err_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    AST_FREEFALL_AND: assert property (eval && comb == FFM_FREEFALL && !latch_en && |(axis_en & above) // [RULE_01]
        |=> !ea_q) else $error("freefall fired with an enabled axis above threshold");
    AST_MOTION_OR: assert property (eval && comb == FFM_MOTION && dbnc_q == '0 && |(axis_en & above) // [RULE_02]
        |=> ea_q) else $error("motion missed on an enabled axis above threshold");
    AST_LIVE_FOLLOWS: assert property (eval && !latch_en |=> ea_q == $past(det)) // [RULE_07]
        else $error("live flag does not follow detection");
    AST_LATCH_HOLD: assert property (latch_en && ea_q && !src_read |=> ea_q) // [RULE_06]
        else $error("latched flag dropped without a source read");
    AST_LATCH_READ_CLR: assert property (latch_en && src_read && !eval |=> !ea_q && flags_q == '0) // [RULE_06]
        else $error("source read did not clear latched event");
    AST_FREEZE: assert property (hold && !src_read |=> $stable(flags_q)) // [RULE_09]
        else $error("held source flags changed");
    AST_AXIS_OFF: assert property (eval && !hold && !axis_en[0] |=> !flags_q[1]) // [RULE_11]
        else $error("disabled X axis raised its flag");
    AST_DBNC_CLEAR: assert property (eval && !cond && ths_q[`FFM_THS_DBCNTM] |=> cnt_q == '0) // [RULE_13]
        else $error("debounce counter not cleared");
    AST_DBNC_DEC: assert property (eval && !cond && !ths_q[`FFM_THS_DBCNTM] && cnt_q != '0 // [RULE_13]
        |=> cnt_q == $past(cnt_q) - 1'b1) else $error("debounce counter not decremented");
    AST_IRQ: assert property (ev_set |=> stat_q[0] && irq == mask_q[0]) // [RULE_15]
        else $error("new event did not set status or irq");
    COV_FREEFALL: cover property (eval && det && comb == FFM_FREEFALL);
    COV_MOTION: cover property (eval && det && comb == FFM_MOTION);
    COV_LATCH_CLEAR: cover property (hold && src_read ##1 !ea_q);

endmodule // ffm_detector

// File: verification/ffm_accel_src.sv
`timescale 1ns/1ps

module ffm_accel_src import ffm_pkg::*; (
    // Clock
    input wire logic pclk,
    // Sample out
    output logic sample_valid,
    output ffm_sample_t sample_x,
    output ffm_sample_t sample_y,
    output ffm_sample_t sample_z
);
    // ----------------------------------------------------------------
    // Sample path model
    // ----------------------------------------------------------------
    // Idle lines start low
    initial begin
        sample_valid = 1'b0;
        sample_x = '0;
        sample_y = '0;
        sample_z = '0;
    end

    // One-cycle pulse; lines invert afterwards so stale data never looks valid
    task automatic send(input ffm_sample_t x, input ffm_sample_t y, input ffm_sample_t z);
        @(posedge pclk);
        sample_valid <= 1'b1;
        sample_x <= x;
        sample_y <= y;
        sample_z <= z;
        @(posedge pclk);
        sample_valid <= 1'b0;
        sample_x <= ~x;
        sample_y <= ~y;
        sample_z <= ~z;
    endtask
endmodule // ffm_accel_src

// File: verification/freefall_motion_detector_tb_top.sv
`timescale 1ns/1ps
`include "ffm_params.svh"

module freefall_motion_detector_tb_top import ffm_pkg::*; ;
    // ----------------------------------------------------------------
    // Signals and instances
    // ----------------------------------------------------------------
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready, pslverr, sample_valid, event_active_flag, irq;
    ffm_sample_t sample_x, sample_y, sample_z;
    int fails = 0;
    int n_checks = 0;
    logic [31:0] rd;
    logic er;

    ffm_detector u_ffm_detector (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sample_valid(sample_valid), .sample_x(sample_x), .sample_y(sample_y),
        .sample_z(sample_z), .event_active_flag(event_active_flag), .irq(irq));
    ffm_accel_src u_ffm_accel_src (.pclk(pclk), .sample_valid(sample_valid), .sample_x(sample_x),
        .sample_y(sample_y), .sample_z(sample_z));

    // 20 MHz clock
    initial begin
        forever #25 pclk = ~pclk;
    end

    // ----------------------------------------------------------------
    // Checking and bus tasks
    // ----------------------------------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Setup, then access held until pready; byte address is four times the index
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h00_0000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            fails++;
            complete_run();
        end
    endtask

    task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        chk_reg(rd, {24'h00_0000, exp});
    endtask

    // Sample, let the evaluation edge pass, then look at the flag
    task automatic smp(input ffm_sample_t x, input ffm_sample_t y, input ffm_sample_t z, input logic e);
        u_ffm_accel_src.send(x, y, z);
        repeat (2) @(posedge pclk);
        #1;
        chk_bit(event_active_flag, e);
    endtask

    // Eight samples on X, one per pattern bit, high bit first
    task automatic seq(input logic [7:0] pat);
        for (int i = 7; i >= 0; i--) begin
            u_ffm_accel_src.send(pat[i] ? 14'h00C8 : 14'h0000, 14'h0000, 14'h0000);
        end
        repeat (2) @(posedge pclk);
        #1;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    // Reset values and a refused access
    task automatic t_reset();
        logic [7:0] idx [7];
        idx = '{`FFM_IDX_CFG, `FFM_IDX_SRC, `FFM_IDX_THS, `FFM_IDX_THS_X_MSB, `FFM_IDX_DBNC,
            `FFM_IDX_IRQ_STAT, `FFM_IDX_IRQ_MASK};
        foreach (idx[i]) rdchk(idx[i], 8'h00);
        apb(1'b0, 8'h10, 8'h00);
        chk_bit(er, 1'b1);
        chk_reg(rd, 32'h0000_0000);
        chk_bit(event_active_flag, 1'b0);
    endtask

    // Motion per axis, common threshold of 1 step = 64 counts, strict
    task automatic t_motion();
        ffm_sample_t s [3];
        apb(1'b1, `FFM_IDX_THS, 8'h01);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, `FFM_IDX_CFG, 8'h40 | (8'h08 << i));
            s = '{default: 14'h0000};
            s[i] = 14'h3F38;
            smp(s[0], s[1], s[2], 1'b1);
            rdchk(`FFM_IDX_SRC, 8'h80 | (8'h03 << (2 * i)));
            s = '{default: 14'h03E8};
            s[i] = 14'h0040;
            smp(s[0], s[1], s[2], 1'b0);
            s[i] = 14'h0041;
            smp(s[0], s[1], s[2], 1'b1);
        end
        smp(14'h0000, 14'h0000, 14'h0000, 1'b0);
    endtask

    // Freefall needs every enabled axis low
    task automatic t_freefall();
        apb(1'b1, `FFM_IDX_CFG, 8'h38);
        apb(1'b1, `FFM_IDX_THS, 8'h02);
        smp(14'h0010, 14'h3FF0, 14'h0080, 1'b1);
        smp(14'h0010, 14'h0081, 14'h0010, 1'b0);
    endtask

    // Per-axis 13-bit threshold of 100 on X overrides a large common one
    task automatic t_axis_ths();
        apb(1'b1, `FFM_IDX_CFG, 8'h48);
        apb(1'b1, `FFM_IDX_THS, 8'h7F);
        apb(1'b1, `FFM_IDX_THS_X_MSB, 8'h81);
        apb(1'b1, `FFM_IDX_THS_X_MSB + 8'h01, 8'h24);
        smp(14'h0065, 14'h0000, 14'h0000, 1'b1);
        smp(14'h0064, 14'h0000, 14'h0000, 1'b0);
        apb(1'b1, `FFM_IDX_THS_X_MSB, 8'h01);
        smp(14'h0065, 14'h0000, 14'h0000, 1'b0);
        apb(1'b1, `FFM_IDX_THS_X_MSB + 8'h02, 8'hFF);
        rdchk(`FFM_IDX_THS_X_MSB + 8'h02, 8'h7F);
        apb(1'b1, `FFM_IDX_THS_X_MSB + 8'h05, 8'hFF);
        rdchk(`FFM_IDX_THS_X_MSB + 8'h05, 8'h3F);
    endtask

    // Latched event freezes the source flags until the source is read
    task automatic t_latch();
        apb(1'b1, `FFM_IDX_THS, 8'h01);
        apb(1'b1, `FFM_IDX_CFG, 8'hD8);
        smp(14'h3F38, 14'h0000, 14'h0000, 1'b1);
        smp(14'h0000, 14'h012C, 14'h0000, 1'b1);
        rdchk(`FFM_IDX_SRC, 8'h83);
        @(posedge pclk);
        #1;
        chk_bit(event_active_flag, 1'b0);
    endtask

    // Debounce of 3: clear mode drops the count, decrement mode keeps most of it
    task automatic t_debounce();
        apb(1'b1, `FFM_IDX_CFG, 8'h48);
        apb(1'b1, `FFM_IDX_DBNC, 8'h03);
        apb(1'b1, `FFM_IDX_THS, 8'h81);
        seq(8'h00);
        smp(14'h00C8, 14'h0000, 14'h0000, 1'b0);
        seq(8'b1111_1011);
        chk_bit(event_active_flag, 1'b0);
        apb(1'b1, `FFM_IDX_THS, 8'h01);
        seq(8'h00);
        seq(8'b1111_1011);
        chk_bit(event_active_flag, 1'b1);
        apb(1'b1, `FFM_IDX_DBNC, 8'h00);
        smp(14'h0000, 14'h0000, 14'h0000, 1'b0);
    endtask

    // Sticky status, mask and write-one-to-clear
    task automatic t_irq();
        apb(1'b1, `FFM_IDX_IRQ_STAT, 8'h01);
        rdchk(`FFM_IDX_IRQ_STAT, 8'h00);
        smp(14'h00C8, 14'h0000, 14'h0000, 1'b1);
        rdchk(`FFM_IDX_IRQ_STAT, 8'h01);
        chk_bit(irq, 1'b0);
        apb(1'b1, `FFM_IDX_IRQ_MASK, 8'h01);
        #1;
        chk_bit(irq, 1'b1);
        apb(1'b1, `FFM_IDX_IRQ_STAT, 8'h01);
        #1;
        chk_bit(irq, 1'b0);
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_motion();
        t_freefall();
        t_axis_ths();
        t_latch();
        t_debounce();
        t_irq();
        complete_run();
    end
endmodule // freefall_motion_detector_tb_top
